// ---- pkg/cccr_consts.svh ----
// Offsets, field positions, reset values and timing figures of the charger control registers
`ifndef CCCR_CONSTS_SVH
`define CCCR_CONSTS_SVH

`define CCCR_OFF_CTRL_TWO_TAIL   8'h11
`define CCCR_OFF_CTRL_THREE      8'h12
`define CCCR_OFF_CTRL_FOUR       8'h13

// Low field of the control two register
`define CCCR_B_SHIP_DLY_SKIP     0
`define CCCR_B_SHIP_ACT_LO       1
`define CCCR_B_SHIP_ACT_HI       2
`define CCCR_RST_TAIL            3'h0

// Control three register
`define CCCR_B_GATE_KILL         7
`define CCCR_B_REV_BOOST         6
`define CCCR_B_REV_PSKIP_OFF     5
`define CCCR_B_FWD_PSKIP_OFF     4
`define CCCR_B_WAKE_HOLD_SEL     3
`define CCCR_B_PRECHG_LIN_OFF    2
`define CCCR_B_REV_OOA_OFF       1
`define CCCR_B_FWD_OOA_OFF       0
`define CCCR_RST_THREE           8'h00
// Bits of control three cleared by host timer expiry
`define CCCR_WD_MASK_THREE       8'h66

// Control four register
`define CCCR_B_PATH_TWO_ON       7
`define CCCR_B_PATH_ONE_ON       6
`define CCCR_B_SW_RATE           5
`define CCCR_B_STAT_OFF          4
`define CCCR_B_SYS_SHORT_OFF     3
`define CCCR_B_REV_UV_OFF        2
`define CCCR_B_LIMIT_TRIG        1
`define CCCR_B_IN_OCP_ON         0
`define CCCR_RST_FOUR            8'h01
`define CCCR_WD_MASK_FOUR        8'h10

// Timing figures
`define CCCR_CLK_NS              5
`define CCCR_MS_NS               1000000
`define CCCR_SHIP_DELAY_S        10
`define CCCR_WAKE_LONG_S         1
`define CCCR_WAKE_SHORT_MS       15
`define CCCR_WDOG_S              40
`define CCCR_MS_PER_S            1000

`endif

// ---- pkg/cccr_pkg.sv ----
// Types shared by the charger control register bank
package cccr_pkg;

   typedef enum logic [1:0] {
      CCCR_ACT_IDLE,
      CCCR_ACT_SHUTDOWN,
      CCCR_ACT_SHIP,
      CCCR_ACT_SYS_RESET
   } cccr_ship_act_t;

   typedef enum logic [1:0] {
      CCCR_DET_IDLE,
      CCCR_DET_REQ,
      CCCR_DET_WAIT
   } cccr_det_state_t;

endpackage : cccr_pkg

// ---- rtl/cccr_regs.sv ----
// Charger control configuration register bank with ship, wake, watchdog and limit detection
// What this block does
// - Ship action waits 10 s unless skipped
// - Gate kill forces both path enables low
// - Reverse boost enable, watchdog and reset cleared
// - Reverse pulse-skip off, watchdog and reset cleared
// - Forward pulse-skip off, reset cleared only
// - Wake pin held low 1 s or 15 ms
// - Pre-charge linear off, watchdog and reset cleared
// - Reverse out-of-audio off, watchdog cleared
// - Forward out-of-audio off, reset cleared only
// - Path two enable, locked low when absent
// - Path one enable, locked low when absent
// - Switching rate bit loads from strap
// - Status pin off, watchdog and reset cleared
// - System short hiccup disable bit
// - Reverse undervoltage hiccup disable bit
// - Limit trigger accepted only above minimum system
// - Trigger pauses, measures, updates limit, self-clears
// - Input overcurrent guard, resets to one
// - Ship action codes idle, shutdown, ship, reset
// - Host timer expiry restores watchdog fields
`timescale 1ns/1ps
`include "cccr_consts.svh"

module cccr_regs #(
   parameter int CYCLES_PER_MS = `CCCR_MS_NS / `CCCR_CLK_NS,
   parameter int WDOG_MS       = `CCCR_WDOG_S * `CCCR_MS_PER_S,
   parameter int SHIP_DELAY_MS = `CCCR_SHIP_DELAY_S * `CCCR_MS_PER_S,
   parameter int WAKE_LONG_MS  = `CCCR_WAKE_LONG_S * `CCCR_MS_PER_S,
   parameter int WAKE_SHORT_MS = `CCCR_WAKE_SHORT_MS
) (
   input  wire logic                    clk,
   input  wire logic                    resetn,
   input  wire logic [7:0]              reg_addr,
   input  wire logic [7:0]              reg_wdata,
   input  wire logic                    reg_wr,
   input  wire logic                    reg_rd,
   output logic [7:0]                   reg_rdata,
   input  wire logic                    reg_reset,
   input  wire logic                    host_timer_kick,
   input  wire logic                    watchdog_enable,
   input  wire logic                    config_strap_pin,
   input  wire logic                    path_one_fitted,
   input  wire logic                    path_two_fitted,
   input  wire logic                    vbat_above_min_system,
   input  wire logic                    wake_pin,
   input  wire logic                    ship_mode_active,
   input  wire logic                    adc_done,
   input  wire logic [7:0]              adc_vbus_code,
   input  wire logic                    charge_status_level,
   output logic                         ship_action_fire,
   output cccr_pkg::cccr_ship_act_t     ship_action_code,
   output logic                         ship_exit,
   output logic                         watchdog_expired,
   output logic                         input_path_one_on,
   output logic                         input_path_two_on,
   output logic                         reverse_boost_enable,
   output logic                         reverse_pulse_skip_off,
   output logic                         forward_pulse_skip_off,
   output logic                         precharge_linear_off,
   output logic                         reverse_out_of_audio_off,
   output logic                         forward_out_of_audio_off,
   output logic                         switching_rate_select,
   output logic                         status_pin_o,
   output logic                         status_pin_oe,
   output logic                         system_short_hiccup_off,
   output logic                         reverse_undervoltage_hiccup_off,
   output logic                         input_overcurrent_guard_on,
   output logic                         converter_pause,
   output logic                         adc_measure_req,
   output logic [7:0]                   input_voltage_limit
);
   import cccr_pkg::*;

   localparam int MSW = $clog2(CYCLES_PER_MS + 1);
   localparam int TW  = 17;

   // Synchronisers: wake, strap, fitted one, fitted two, battery comparator
   logic [4:0]       sync1_q;
   logic [4:0]       sync2_q;
   logic             wake_low_s;
   logic             strap_s;
   logic             one_fit_s;
   logic             two_fit_s;
   logic             vbat_ok_s;

   logic [MSW-1:0]   ms_cnt_q;
   logic             ms_tick;
   logic [TW-1:0]    wd_cnt_q;
   logic             wd_expire_q;
   logic [1:0]       strap_wait_q;
   logic [2:0]       tail_q;
   logic [7:0]       three_q;
   logic [7:0]       four_q;
   logic [7:0]       four_d;
   logic [7:0]       rdata_q;
   logic [TW-1:0]    ship_cnt_q;
   logic             ship_busy_q;
   logic             ship_fire_q;
   logic [TW-1:0]    wake_cnt_q;
   logic             wake_exit_q;
   logic             stat_q;
   logic [7:0]       ivl_q;
   cccr_det_state_t  det_q;
   logic             wr_tail;
   logic             wr_three;
   logic             wr_four;
   logic             kill_next;
   logic             det_done;
   logic [TW-1:0]    wake_hold;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         sync1_q <= 5'h00;
         sync2_q <= 5'h00;
      end else begin
         sync1_q <= {~wake_pin, config_strap_pin, path_one_fitted, path_two_fitted,
                     vbat_above_min_system};
         sync2_q <= sync1_q;
      end
   end

   assign wake_low_s = sync2_q[4];
   assign strap_s    = sync2_q[3];
   assign one_fit_s  = sync2_q[2];
   assign two_fit_s  = sync2_q[1];
   assign vbat_ok_s  = sync2_q[0];

   assign wr_tail  = reg_wr && (reg_addr == `CCCR_OFF_CTRL_TWO_TAIL);
   assign wr_three = reg_wr && (reg_addr == `CCCR_OFF_CTRL_THREE);
   assign wr_four  = reg_wr && (reg_addr == `CCCR_OFF_CTRL_FOUR);

   // Millisecond enable so all long timers stay narrow
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         ms_cnt_q <= '0;
      end else if (ms_cnt_q == MSW'(CYCLES_PER_MS - 1)) begin
         ms_cnt_q <= '0;
      end else begin
         ms_cnt_q <= ms_cnt_q + MSW'(1);
      end
   end
   assign ms_tick = (ms_cnt_q == MSW'(CYCLES_PER_MS - 1));

   // Host watchdog, restarted by a kick, a register reset or while disabled
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         wd_cnt_q    <= '0;
         wd_expire_q <= 1'b0;
      end else begin
         wd_expire_q <= 1'b0;
         if (host_timer_kick || reg_reset || !watchdog_enable) begin
            wd_cnt_q <= '0;
         end else if (ms_tick) begin
            if (wd_cnt_q == TW'(WDOG_MS - 1)) begin
               wd_cnt_q    <= '0;
               wd_expire_q <= 1'b1;
            end else begin
               wd_cnt_q <= wd_cnt_q + TW'(1);
            end
         end
      end
   end

   // Strap is caught once the synchroniser has settled after release
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         strap_wait_q <= 2'h0;
      end else if (strap_wait_q != 2'h3) begin
         strap_wait_q <= strap_wait_q + 2'h1;
      end
   end

   // Ship action field and its delay skip; only register reset clears them
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         tail_q <= `CCCR_RST_TAIL;
      end else if (reg_reset) begin
         tail_q <= `CCCR_RST_TAIL;
      end else if (wr_tail) begin
         tail_q <= reg_wdata[2:0];
      end
   end

   assign kill_next = wr_three ? reg_wdata[`CCCR_B_GATE_KILL] : three_q[`CCCR_B_GATE_KILL];

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         three_q <= `CCCR_RST_THREE;
      end else if (reg_reset) begin
         three_q <= `CCCR_RST_THREE;
      end else if (wr_three) begin
         three_q <= reg_wdata;
      end else if (wd_expire_q) begin
         three_q <= three_q & ~`CCCR_WD_MASK_THREE;
      end
   end

   // Next value of control four; path enables obey kill and fitting
   always_comb begin
      four_d = four_q;
      if (wr_four) begin
         four_d = {reg_wdata[7:2], four_q[`CCCR_B_LIMIT_TRIG], reg_wdata[0]};
         if (reg_wdata[`CCCR_B_LIMIT_TRIG] && vbat_ok_s) begin
            four_d[`CCCR_B_LIMIT_TRIG] = 1'b1;
         end
      end else if (wd_expire_q) begin
         four_d = four_q & ~`CCCR_WD_MASK_FOUR;
      end
      // Clear by the detector loses to a fresh accepted trigger
      if (det_done && !(wr_four && reg_wdata[`CCCR_B_LIMIT_TRIG] && vbat_ok_s)) begin
         four_d[`CCCR_B_LIMIT_TRIG] = 1'b0;
      end
      if (kill_next) begin
         four_d[`CCCR_B_PATH_TWO_ON] = 1'b0;
         four_d[`CCCR_B_PATH_ONE_ON] = 1'b0;
      end
      if (!two_fit_s) begin
         four_d[`CCCR_B_PATH_TWO_ON] = 1'b0;
      end
      if (!one_fit_s) begin
         four_d[`CCCR_B_PATH_ONE_ON] = 1'b0;
      end
      if (reg_reset) begin
         four_d = `CCCR_RST_FOUR;
         four_d[`CCCR_B_SW_RATE] = strap_s;
      end
      if (strap_wait_q == 2'h2) begin
         four_d[`CCCR_B_SW_RATE] = strap_s;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         four_q <= `CCCR_RST_FOUR;
      end else begin
         four_q <= four_d;
      end
   end

   // Read port: data one cycle after the strobe, unmapped offsets read zero
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rdata_q <= 8'h00;
      end else if (reg_rd) begin
         case (reg_addr)
            `CCCR_OFF_CTRL_TWO_TAIL: rdata_q <= {5'h00, tail_q};
            `CCCR_OFF_CTRL_THREE:    rdata_q <= three_q;
            `CCCR_OFF_CTRL_FOUR:     rdata_q <= four_q;
            default:                 rdata_q <= 8'h00;
         endcase
      end
   end
   assign reg_rdata = rdata_q;

   // Ship action timer; a new delayed write restarts it, a skip write fires at once, idle cancels it
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         ship_busy_q <= 1'b0;
         ship_cnt_q  <= '0;
         ship_fire_q <= 1'b0;
      end else begin
         ship_fire_q <= 1'b0;
         if (reg_reset) begin
            ship_busy_q <= 1'b0;
         end else if (wr_tail) begin
            ship_cnt_q <= '0;
            if (reg_wdata[2:1] == 2'h0) begin
               ship_busy_q <= 1'b0;
            end else if (reg_wdata[`CCCR_B_SHIP_DLY_SKIP]) begin
               ship_busy_q <= 1'b0;
               ship_fire_q <= 1'b1;
            end else begin
               ship_busy_q <= 1'b1;
            end
         end else if (ship_busy_q && ms_tick) begin
            if (ship_cnt_q == TW'(SHIP_DELAY_MS - 1)) begin
               ship_busy_q <= 1'b0;
               ship_fire_q <= 1'b1;
            end else begin
               ship_cnt_q <= ship_cnt_q + TW'(1);
            end
         end
      end
   end
   assign ship_action_fire = ship_fire_q;
   assign ship_action_code = cccr_ship_act_t'(tail_q[2:1]);

   // Wake hold: a release before the full time restarts the count
   assign wake_hold = three_q[`CCCR_B_WAKE_HOLD_SEL] ? TW'(WAKE_SHORT_MS) : TW'(WAKE_LONG_MS);

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         wake_cnt_q  <= '0;
         wake_exit_q <= 1'b0;
      end else begin
         wake_exit_q <= 1'b0;
         if (!(ship_mode_active && wake_low_s)) begin
            wake_cnt_q <= '0;
         end else if (ms_tick && wake_cnt_q < wake_hold) begin
            wake_cnt_q <= wake_cnt_q + TW'(1);
            if (wake_cnt_q == wake_hold - TW'(1)) begin
               wake_exit_q <= 1'b1;
            end
         end
      end
   end
   assign ship_exit = wake_exit_q;

   // Input limit detection: pause, ask for a measurement, store it
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         det_q <= CCCR_DET_IDLE;
         ivl_q <= 8'h00;
      end else begin
         case (det_q)
            CCCR_DET_IDLE: begin
               if (four_q[`CCCR_B_LIMIT_TRIG]) begin
                  det_q <= CCCR_DET_REQ;
               end
            end
            CCCR_DET_REQ: begin
               det_q <= CCCR_DET_WAIT;
            end
            CCCR_DET_WAIT: begin
               if (adc_done) begin
                  ivl_q <= adc_vbus_code;
                  det_q <= CCCR_DET_IDLE;
               end
            end
            default: begin
               det_q <= CCCR_DET_IDLE;
            end
         endcase
      end
   end
   assign det_done            = (det_q == CCCR_DET_WAIT) && adc_done;
   assign converter_pause     = (det_q != CCCR_DET_IDLE);
   assign adc_measure_req     = (det_q == CCCR_DET_REQ);
   assign input_voltage_limit = ivl_q;

   // Status pin stays undriven while disabled
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         stat_q <= 1'b0;
      end else begin
         stat_q <= charge_status_level;
      end
   end
   assign status_pin_o  = stat_q;
   assign status_pin_oe = ~four_q[`CCCR_B_STAT_OFF];

   assign watchdog_expired                = wd_expire_q;
   assign input_path_one_on               = four_q[`CCCR_B_PATH_ONE_ON];
   assign input_path_two_on               = four_q[`CCCR_B_PATH_TWO_ON];
   assign reverse_boost_enable            = three_q[`CCCR_B_REV_BOOST];
   assign reverse_pulse_skip_off          = three_q[`CCCR_B_REV_PSKIP_OFF];
   assign forward_pulse_skip_off          = three_q[`CCCR_B_FWD_PSKIP_OFF];
   assign precharge_linear_off            = three_q[`CCCR_B_PRECHG_LIN_OFF];
   assign reverse_out_of_audio_off        = three_q[`CCCR_B_REV_OOA_OFF];
   assign forward_out_of_audio_off        = three_q[`CCCR_B_FWD_OOA_OFF];
   assign switching_rate_select           = four_q[`CCCR_B_SW_RATE];
   assign system_short_hiccup_off         = four_q[`CCCR_B_SYS_SHORT_OFF];
   assign reverse_undervoltage_hiccup_off = four_q[`CCCR_B_REV_UV_OFF];
   assign input_overcurrent_guard_on      = four_q[`CCCR_B_IN_OCP_ON];

   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   a_kill_paths_low: assert property (
      three_q[`CCCR_B_GATE_KILL] |-> !input_path_one_on && !input_path_two_on)
      else $error("Path enable high under gate kill");

   a_absent_path_low: assert property (
      $past(!two_fit_s) |-> !input_path_two_on)
      else $error("Absent path two enabled");

   a_wd_clears_boost: assert property (
      wd_expire_q && !wr_three && !wr_four && !reg_reset
      |=> !reverse_boost_enable && !four_q[`CCCR_B_STAT_OFF])
      else $error("Watchdog expiry left fields set");

   a_wd_keeps_fwd: assert property (
      wd_expire_q && !wr_three && !reg_reset |=> $stable(forward_pulse_skip_off))
      else $error("Watchdog expiry touched forward field");

   a_trig_needs_vbat: assert property (
      !four_q[`CCCR_B_LIMIT_TRIG] && !(wr_four && vbat_ok_s) && !reg_reset
      |=> !four_q[`CCCR_B_LIMIT_TRIG])
      else $error("Trigger set without battery condition");

   a_trig_measures: assert property (
      det_q == CCCR_DET_IDLE && four_q[`CCCR_B_LIMIT_TRIG] |=> adc_measure_req)
      else $error("Trigger did not request a measurement");

   a_limit_updates: assert property (
      det_done |=> input_voltage_limit == $past(adc_vbus_code) && converter_pause == 1'b0)
      else $error("Limit not updated after measurement");

   a_reset_defaults: assert property (
      reg_reset |=> three_q == `CCCR_RST_THREE && input_overcurrent_guard_on
      && switching_rate_select == $past(strap_s) && tail_q == `CCCR_RST_TAIL)
      else $error("Register reset left non-default value");

   a_skip_fires_now: assert property (
      wr_tail && !reg_reset && reg_wdata[2:1] != 2'h0 && reg_wdata[0] |=> ship_action_fire)
      else $error("Undelayed ship action not issued");

   a_delay_no_early: assert property (
      wr_tail && !reg_reset && reg_wdata[2:1] != 2'h0 && !reg_wdata[0]
      |=> !ship_action_fire [*8])
      else $error("Delayed ship action fired early");

   a_wake_needs_hold: assert property (
      ship_exit |-> $past(wake_cnt_q) == wake_hold - TW'(1))
      else $error("Ship exit before hold time");

   c_ship_fire:   cover property (ship_action_fire);
   c_wake_exit:   cover property (ship_exit);
   c_limit_done:  cover property (det_done);
   c_wd_expire:   cover property (wd_expire_q);

endmodule : cccr_regs

// ---- test/cccr_host_model.sv ----
// Host side model driving the register strobe port and the timer kick
`timescale 1ns/1ps
module cccr_host_model (
   input  wire logic       clk,
   output logic [7:0]      reg_addr,
   output logic [7:0]      reg_wdata,
   output logic            reg_wr,
   output logic            reg_rd,
   input  wire logic [7:0] reg_rdata,
   output logic            host_timer_kick
);
   initial begin
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      host_timer_kick = 1'b0;
   end

   // One strobe cycle per access, signals change on the falling edge only
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge clk);
      reg_wr = 1'b0;
      // Released data is inverted so stale bus values cannot pass for valid ones
      reg_wdata = ~d;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge clk);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge clk);
      reg_rd = 1'b0;
      d = reg_rdata;
   endtask : rd

   task automatic kick();
      @(negedge clk);
      host_timer_kick = 1'b1;
      @(negedge clk);
      host_timer_kick = 1'b0;
   endtask : kick
endmodule : cccr_host_model

// ---- test/test_charger_control_config_regs.sv ----
// Self-checking bench of the charger control register bank
`timescale 1ns/1ps
module test_charger_control_config_regs;
   import cccr_pkg::*;
   logic           clk, reg_wr, reg_rd, host_timer_kick, ship_action_fire, ship_exit;
   logic           watchdog_expired, input_path_one_on, input_path_two_on, status_pin_o;
   logic           reverse_boost_enable, reverse_pulse_skip_off, forward_pulse_skip_off;
   logic           precharge_linear_off, reverse_out_of_audio_off, forward_out_of_audio_off;
   logic           switching_rate_select, status_pin_oe, system_short_hiccup_off;
   logic           reverse_undervoltage_hiccup_off, input_overcurrent_guard_on;
   logic           converter_pause, adc_measure_req;
   logic           resetn = 1'b0, reg_reset = 1'b0, watchdog_enable = 1'b0;
   logic           config_strap_pin = 1'b1, path_one_fitted = 1'b1, path_two_fitted = 1'b1;
   logic           vbat_above_min_system = 1'b0, wake_pin = 1'b1, ship_mode_active = 1'b0;
   logic           adc_done = 1'b0, charge_status_level = 1'b0;
   logic [7:0]     adc_vbus_code = 8'h00;
   logic [7:0]     reg_addr, reg_wdata, reg_rdata, input_voltage_limit, rdv;
   logic [3:0]     ev;
   cccr_ship_act_t ship_action_code;
   int             mismatches = 0, samples_checked = 0, cyc = 0, n;

   // Short counts keep every timed action within a few dozen cycles
   cccr_regs #(.CYCLES_PER_MS(4), .WDOG_MS(10), .SHIP_DELAY_MS(5), .WAKE_LONG_MS(6),
               .WAKE_SHORT_MS(3)) u_dut (
      .clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .reg_reset,
      .host_timer_kick, .watchdog_enable, .config_strap_pin, .path_one_fitted,
      .path_two_fitted, .vbat_above_min_system, .wake_pin, .ship_mode_active, .adc_done,
      .adc_vbus_code, .charge_status_level, .ship_action_fire, .ship_action_code, .ship_exit,
      .watchdog_expired, .input_path_one_on, .input_path_two_on, .reverse_boost_enable,
      .reverse_pulse_skip_off, .forward_pulse_skip_off, .precharge_linear_off,
      .reverse_out_of_audio_off, .forward_out_of_audio_off, .switching_rate_select,
      .status_pin_o, .status_pin_oe, .system_short_hiccup_off,
      .reverse_undervoltage_hiccup_off, .input_overcurrent_guard_on, .converter_pause,
      .adc_measure_req, .input_voltage_limit);
   cccr_host_model u_host (.clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
                           .host_timer_kick);
   assign ev = {adc_measure_req, ship_exit, ship_action_fire, watchdog_expired};

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   task automatic summarize();
      if (mismatches == 0 && samples_checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : summarize

   // Whole run needs under four hundred cycles
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         mismatches++;
         summarize();
      end
   end

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask : chk

   task automatic ok(input logic c);
      chk({7'h0, c}, 8'h01);
   endtask : ok

   task automatic rdc(input logic [7:0] a, input logic [7:0] e);
      u_host.rd(a, rdv);
      chk(rdv, e);
   endtask : rdc

   // Falling edges until the chosen event shows, giving up after hi
   task automatic span(input int b, input int hi);
      n = 0;
      while (ev[b] !== 1'b1 && n < hi) begin
         @(negedge clk);
         n++;
      end
   endtask : span

   task automatic t_reset();
      rdc(8'h11, 8'h00);
      rdc(8'h12, 8'h00);
      rdc(8'h13, 8'h21);
      rdc(8'h20, 8'h00);
   endtask : t_reset

   task automatic t_fields();
      u_host.wr(8'h12, 8'h7f);
      rdc(8'h12, 8'h7f);
      chk({2'h0, reverse_boost_enable, reverse_pulse_skip_off, forward_pulse_skip_off,
           precharge_linear_off, reverse_out_of_audio_off, forward_out_of_audio_off},
          8'h3f);
      u_host.wr(8'h13, 8'h3d);
      rdc(8'h13, 8'h3d);
      chk({3'h0, switching_rate_select, status_pin_oe, system_short_hiccup_off,
           reverse_undervoltage_hiccup_off, input_overcurrent_guard_on}, 8'h17);
      watchdog_enable = 1'b1;
      repeat (3) begin
         repeat (20) @(negedge clk);
         u_host.kick();
      end
      rdc(8'h12, 8'h7f);
      span(0, 60);
      ok(n >= 30 && n <= 46);
      rdc(8'h12, 8'h19);
      rdc(8'h13, 8'h2d);
      watchdog_enable = 1'b0;
      u_host.wr(8'h13, 8'h01);
      charge_status_level = 1'b1;
      repeat (2) @(negedge clk);
      chk({6'h0, status_pin_oe, status_pin_o}, 8'h03);
   endtask : t_fields

   task automatic t_gate();
      u_host.wr(8'h13, 8'hc1);
      chk({6'h0, input_path_two_on, input_path_one_on}, 8'h03);
      u_host.wr(8'h12, 8'h80);
      chk({6'h0, input_path_two_on, input_path_one_on}, 8'h00);
      rdc(8'h13, 8'h01);
      u_host.wr(8'h12, 8'h00);
      path_two_fitted = 1'b0;
      repeat (3) @(negedge clk);
      u_host.wr(8'h13, 8'hc1);
      rdc(8'h13, 8'h41);
      path_two_fitted = 1'b1;
      path_one_fitted = 1'b0;
      repeat (3) @(negedge clk);
      u_host.wr(8'h13, 8'hc1);
      chk({6'h0, input_path_two_on, input_path_one_on}, 8'h02);
      path_one_fitted = 1'b1;
   endtask : t_gate

   task automatic t_ship();
      for (int c = 1; c < 4; c++) begin
         u_host.wr(8'h11, {5'h0, c[1:0], 1'b1});
         span(1, 4);
         ok(n < 4);
         chk({6'h0, ship_action_code}, {6'h0, c[1:0]});
      end
      u_host.wr(8'h11, 8'h04);
      span(1, 40);
      ok(n >= 14 && n <= 26);
      u_host.wr(8'h11, 8'h04);
      repeat (5) @(negedge clk);
      u_host.wr(8'h11, 8'h00);
      span(1, 40);
      ok(n == 40);
   endtask : t_ship

   task automatic t_wake();
      ship_mode_active = 1'b1;
      u_host.wr(8'h12, 8'h08);
      wake_pin = 1'b0;
      span(2, 40);
      ok(n >= 8 && n <= 18);
      wake_pin = 1'b1;
      u_host.wr(8'h12, 8'h00);
      wake_pin = 1'b0;
      span(2, 60);
      ok(n >= 20 && n <= 34);
      wake_pin = 1'b1;
      ship_mode_active = 1'b0;
   endtask : t_wake

   task automatic t_limit();
      u_host.wr(8'h13, 8'h03);
      rdc(8'h13, 8'h01);
      vbat_above_min_system = 1'b1;
      adc_vbus_code = 8'h5a;
      repeat (3) @(negedge clk);
      u_host.wr(8'h13, 8'h03);
      span(3, 4);
      ok(n < 4);
      ok(converter_pause);
      repeat (3) @(negedge clk);
      adc_done = 1'b1;
      @(negedge clk);
      adc_done = 1'b0;
      repeat (2) @(negedge clk);
      chk(input_voltage_limit, 8'h5a);
      ok(!converter_pause);
      rdc(8'h13, 8'h01);
   endtask : t_limit

   task automatic t_regrst();
      u_host.wr(8'h12, 8'h5a);
      u_host.wr(8'h11, 8'h04);
      @(negedge clk);
      reg_reset = 1'b1;
      @(negedge clk);
      reg_reset = 1'b0;
      span(1, 40);
      ok(n == 40);
      rdc(8'h11, 8'h00);
      rdc(8'h12, 8'h00);
      rdc(8'h13, 8'h21);
   endtask : t_regrst

   initial begin
      repeat (2) @(negedge clk);
      resetn = 1'b1;
      repeat (4) @(negedge clk);
      t_reset();
      t_fields();
      t_gate();
      t_ship();
      t_wake();
      t_limit();
      t_regrst();
      summarize();
   end
endmodule : test_charger_control_config_regs
